// *** rimb_host_model.sv ***
// Host model: two-wire serial bus master for the mask bank.
// Assumes the testbench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module rimb_host_model
  import rimb_pkg::*;
(
  // Clock
  input  wire logic       mclk,
  // Bus lines
  input  wire logic       sda_in,
  output logic            scl,
  output logic            sda_low,
  // Byte results: ack as 0 or 1, or read data
  output logic            res_stb,
  output logic [7:0]      res_byte
);
  initial begin
    scl      = 1'b1;
    sda_low  = 1'b0;
    res_stb  = 1'b0;
    res_byte = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every scl phase lasts at least 3 mclk so the slave sees each level
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  task automatic put(input logic [7:0] v);
    res_byte = v;
    res_stb  = 1'b1;
    tick(1);
    res_stb  = 1'b0;
  endtask : put

  task automatic start;
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask : start

  task automatic stop;
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(4);
  endtask : stop

  task automatic send(input logic [7:0] b);
    logic ack;
    for (int i = 7; i >= 0; i--) begin
      sda_low = !b[i];
      tick(3);
      scl = 1'b1;
      tick(4);
      scl = 1'b0;
      tick(1);
    end
    sda_low = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(2);
    ack = !sda_in;
    tick(2);
    scl = 1'b0;
    put({7'h00, ack});
  endtask : send

  task automatic recv(input logic last);
    logic [7:0] b;
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      tick(3);
      scl = 1'b1;
      tick(2);
      b[i] = sda_in;
      tick(2);
      scl = 1'b0;
      tick(1);
    end
    sda_low = !last;
    tick(3);
    scl = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(1);
    sda_low = 1'b0;
    put(b);
  endtask : recv

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] d);
    start();
    send({dev, 1'b0});
    send(ptr);
    send(d);
    stop();
  endtask : write_reg

  task automatic read_regs(input logic [7:0] ptr, input int n);
    start();
    send({DEV_ADDR_DEFAULT, 1'b0});
    send(ptr);
    start();
    send({DEV_ADDR_DEFAULT, 1'b1});
    for (int k = 0; k < n; k++) recv(k == n - 1);
    stop();
  endtask : read_regs
endmodule : rimb_host_model
`default_nettype wire

// *** rimb_mask_bank.sv ***
// Regulator interrupt mask bank: mask registers, edge detection on the raw
// converter and linear-regulator status, interrupt flags and the irq pin.
// Assumes raw status inputs are synchronous to mclk; flags are cleared by
// the flag-register logic outside through one-cycle clear pulses.
`timescale 1ns/1ps
`default_nettype none
module rimb_mask_bank
  import rimb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Serial bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // One-time-programmable default of the reset-event mask
  input  wire logic       otp_reset_mask,
  // Raw regulator status, power-good 1 means output invalid
  input  wire logic       conv0_pg_raw,
  input  wire logic       conv0_curlim_raw,
  input  wire logic       conv1_pg_raw,
  input  wire logic       conv1_curlim_raw,
  input  wire logic       lin0_pg_raw,
  input  wire logic       lin0_curlim_raw,
  input  wire logic       lin1_pg_raw,
  input  wire logic       lin1_curlim_raw,
  input  wire logic       reg_reset_event,
  // Flag clear pulses, index 0 conv0, 1 conv1, 2 lin0, 3 lin1
  input  wire logic [3:0] pg_flag_clr,
  input  wire logic [3:0] curlim_flag_clr,
  input  wire logic       reg_reset_flag_clr,
  // Flags, raw status copy and interrupt pin
  output logic [3:0]      pg_irq_flag,
  output logic [3:0]      curlim_irq_flag,
  output logic            reg_reset_irq_flag,
  output logic [7:0]      raw_status,
  output logic            irq_out_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  rimb_serial_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_slave (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mask registers
  logic [7:0] reset_event_mask;
  logic [7:0] converter_event_mask;
  logic [7:0] linear_reg_event_mask;
  logic       otp_load;

  // The OTP level is caught by a clocked load after release, never by the
  // asynchronous reset itself.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      otp_load <= 1'b1;
    end else begin
      otp_load <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reset_event_mask <= RST_RESET_EVENT_MASK;
    end else begin
      if (otp_load) begin
        reset_event_mask[POS_RESET_EVT] <= otp_reset_mask;
      end
      if (wr_en && wr_addr == OFF_RESET_EVENT_MASK) begin
        // Mask bit itself keeps its loaded value
        reset_event_mask[7:1] <= wr_data[7:1];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      converter_event_mask <= RST_CONVERTER_MASK;
    end else if (wr_en && wr_addr == OFF_CONVERTER_MASK) begin
      converter_event_mask <= wr_data & WR_UNIT_MASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      linear_reg_event_mask <= RST_LINEAR_REG_MASK;
    end else if (wr_en && wr_addr == OFF_LINEAR_REG_MASK) begin
      linear_reg_event_mask <= wr_data & WR_UNIT_MASK;
    end
  end

  always_comb begin
    unique case (rd_addr)
      OFF_RESET_EVENT_MASK: rd_data = reset_event_mask;
      OFF_CONVERTER_MASK:   rd_data = converter_event_mask;
      OFF_LINEAR_REG_MASK:  rd_data = linear_reg_event_mask;
      default:              rd_data = READ_UNMAPPED;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event detection per unit
  function automatic logic mask_bit(input logic [7:0] bank,
                                    input logic       upper,
                                    input logic [2:0] pos);
    mask_bit = bank[{upper, pos[1:0]}];
  endfunction : mask_bit

  logic [3:0] pg_raw;
  logic [3:0] cl_raw;
  logic [3:0] pg_q;
  logic [3:0] cl_q;
  logic [3:0] pg_set;
  logic [3:0] cl_set;
  logic       rr_set;

  assign pg_raw = {lin1_pg_raw, lin0_pg_raw, conv1_pg_raw, conv0_pg_raw};
  assign cl_raw = {lin1_curlim_raw, lin0_curlim_raw,
                   conv1_curlim_raw, conv0_curlim_raw};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pg_q <= 4'h0;
      cl_q <= 4'h0;
    end else begin
      pg_q <= pg_raw;
      cl_q <= cl_raw;
    end
  end

  for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
    logic [7:0] bank;
    logic       up;
    assign bank = (u >= 2) ? linear_reg_event_mask
                           : converter_event_mask;
    assign up   = 1'(u % 2);
    // Invalid-going is a rise of the raw bit, valid-going a fall
    assign pg_set[u] =
      (pg_raw[u] & ~pg_q[u] & ~mask_bit(bank, up, POS_PG_FALL)) |
      (~pg_raw[u] & pg_q[u] & ~mask_bit(bank, up, POS_PG_RISE));
    assign cl_set[u] =
      cl_raw[u] & ~cl_q[u] & ~mask_bit(bank, up, POS_CURLIM);
  end

  assign rr_set = reg_reset_event & ~reset_event_mask[POS_RESET_EVT];

  ////////////////////////////////////////////////////////////////////////////
  // Flags: a set in the same cycle as a clear wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pg_irq_flag        <= 4'h0;
      curlim_irq_flag    <= 4'h0;
      reg_reset_irq_flag <= 1'b0;
    end else begin
      pg_irq_flag     <= pg_set | (pg_irq_flag & ~pg_flag_clr);
      curlim_irq_flag <= cl_set | (curlim_irq_flag & ~curlim_flag_clr);
      reg_reset_irq_flag <= rr_set |
                            (reg_reset_irq_flag & ~reg_reset_flag_clr);
    end
  end

  // Masks never touch this copy of the raw status
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      raw_status <= 8'h00;
    end else begin
      raw_status <= {pg_raw[3], cl_raw[3], pg_raw[2], cl_raw[2],
                     pg_raw[1], cl_raw[1], pg_raw[0], cl_raw[0]};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= ~(|pg_irq_flag | |curlim_irq_flag |
                     reg_reset_irq_flag);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_rst_evt_gate:
    assert property (reg_reset_event && !reset_event_mask[0]
                     |=> reg_reset_irq_flag ##1 1'b1)
    else $error("reset event not flagged while unmasked");

  a_rst_mask_hold:
    assert property (!otp_load && wr_en && wr_addr == OFF_RESET_EVENT_MASK
                     |=> $stable(reset_event_mask[0]))
    else $error("reset-event mask bit changed by a host write");

  a_c1_fall_mask:
    assert property (conv1_pg_raw && !pg_q[1] && converter_event_mask[7]
                     && !pg_irq_flag[1] |=> !pg_irq_flag[1])
    else $error("converter 1 invalid-going event not masked");

  a_c1_rise_open:
    assert property (!conv1_pg_raw && pg_q[1] && !converter_event_mask[6]
                     |=> pg_irq_flag[1])
    else $error("converter 1 valid-going event not flagged");

  a_c1_curlim_mask:
    assert property ($rose(conv1_curlim_raw) && converter_event_mask[4]
                     && !curlim_irq_flag[1] |=> !curlim_irq_flag[1])
    else $error("converter 1 current limit not masked");

  a_c0_fall_open:
    assert property (conv0_pg_raw && !pg_q[0] && !converter_event_mask[3]
                     |=> pg_irq_flag[0])
    else $error("converter 0 invalid-going event not flagged");

  a_c0_rise_mask:
    assert property (!conv0_pg_raw && pg_q[0] && converter_event_mask[2]
                     && !pg_irq_flag[0] |=> !pg_irq_flag[0])
    else $error("converter 0 valid-going event not masked");

  a_c0_curlim_open:
    assert property (conv0_curlim_raw && !cl_q[0] && !converter_event_mask[0]
                     |=> curlim_irq_flag[0])
    else $error("converter 0 current limit not flagged");

  a_raw_status_copy:
    assert property (##1 raw_status[3] == $past(conv1_pg_raw)
                     && raw_status[0] == $past(conv0_curlim_raw))
    else $error("raw status copy does not follow its inputs");

  a_l1_fall_open:
    assert property (lin1_pg_raw && !pg_q[3] && !linear_reg_event_mask[7]
                     |=> pg_irq_flag[3])
    else $error("linear 1 invalid-going event not flagged");

  a_l0_curlim_mask:
    assert property (lin0_curlim_raw && !cl_q[2] && linear_reg_event_mask[0]
                     && !curlim_irq_flag[2] |=> !curlim_irq_flag[2])
    else $error("linear 0 current limit not masked");

  a_irq_pin_level:
    assert property ((|pg_irq_flag || |curlim_irq_flag || reg_reset_irq_flag)
                     |=> !irq_out_n)
    else $error("interrupt pin idle while a flag is pending");

  a_reserved_zero:
    assert property ((converter_event_mask & ~WR_UNIT_MASK) == 8'h00
                     && (linear_reg_event_mask & ~WR_UNIT_MASK) == 8'h00)
    else $error("reserved mask bit is set");

endmodule : rimb_mask_bank
`default_nettype wire

// *** rimb_pkg.sv ***
// Package for the regulator interrupt mask bank: offsets, field positions,
// reset values and serial-bus constants.
// Assumes a byte-wide register space reached over a two-wire serial bus.
package rimb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFF_RESET_EVENT_MASK = 8'h21;
  localparam logic [7:0] OFF_CONVERTER_MASK   = 8'h22;
  localparam logic [7:0] OFF_LINEAR_REG_MASK  = 8'h23;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions inside the low nibble of a converter or linear mask;
  // the unit with index 1 uses the same positions plus four.
  localparam logic [2:0] POS_PG_FALL   = 3'h3;
  localparam logic [2:0] POS_PG_RISE   = 3'h2;
  localparam logic [2:0] POS_CURLIM    = 3'h0;
  localparam int         POS_RESET_EVT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and writable bits
  localparam logic [7:0] RST_RESET_EVENT_MASK = 8'h01;
  localparam logic [7:0] RST_CONVERTER_MASK   = 8'hcc;
  localparam logic [7:0] RST_LINEAR_REG_MASK  = 8'hcc;
  localparam logic [7:0] WR_RESET_EVENT_MASK  = 8'hfe;
  localparam logic [7:0] WR_UNIT_MASK         = 8'hdd;
  localparam logic [7:0] READ_UNMAPPED        = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Regulator units: 0 converter 0, 1 converter 1, 2 linear 0, 3 linear 1
  localparam int NUM_UNITS = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Serial bus
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h5a; // Arbitrary value
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

  typedef enum logic [2:0] {
    RIMB_IDLE,
    RIMB_ADDR,
    RIMB_ACK_ADDR,
    RIMB_PTR,
    RIMB_ACK_WR,
    RIMB_WDATA,
    RIMB_RDATA,
    RIMB_ACK_RD
  } rimb_sbus_state_e;

endpackage : rimb_pkg

// *** rimb_serial_slave.sv ***
// Two-wire serial slave: byte pointer, auto-increment writes and reads.
// Assumes scl and sda inputs are already synchronous to mclk and that the
// register file answers a read address combinationally.
`timescale 1ns/1ps
`default_nettype none
module rimb_serial_slave
  import rimb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Register file side
  output logic            wr_en,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);

  rimb_sbus_state_e state;
  logic             scl_q;
  logic             sda_q;
  logic [7:0]       shreg;
  logic [3:0]       bit_cnt;
  logic [7:0]       ptr;
  logic             rd_dir;
  logic             nack;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_c;
  logic             stop_c;

  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_c  = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_c   = scl_in & scl_q & ~sda_q & sda_in;
  assign sda_out  = 1'b0;
  assign rd_addr  = ptr;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine; a start or stop aborts whatever byte is in flight
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= RIMB_IDLE;
      shreg   <= 8'h00;
      bit_cnt <= 4'h0;
      ptr     <= 8'h00;
      rd_dir  <= 1'b0;
      nack    <= 1'b1;
      sda_oe  <= 1'b0;
      wr_en   <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (start_c) begin
        state   <= RIMB_ADDR;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (stop_c) begin
        state  <= RIMB_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        unique case (state)
          RIMB_ADDR, RIMB_PTR, RIMB_WDATA: begin
            shreg   <= {shreg[6:0], sda_in};
            bit_cnt <= bit_cnt + 4'h1;
          end
          RIMB_RDATA: begin
            shreg   <= {shreg[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
          end
          RIMB_ACK_RD: nack <= sda_in;
          default: ;
        endcase
      end else if (scl_fall) begin
        unique case (state)
          RIMB_ADDR: begin
            if (bit_cnt == BITS_PER_BYTE) begin
              if (shreg[7:1] == DEV_ADDR) begin
                state  <= RIMB_ACK_ADDR;
                rd_dir <= shreg[0];
                sda_oe <= 1'b1;
              end else begin
                state <= RIMB_IDLE;
              end
            end
          end
          RIMB_ACK_ADDR: begin
            bit_cnt <= 4'h0;
            if (rd_dir) begin
              state  <= RIMB_RDATA;
              shreg  <= rd_data;
              sda_oe <= ~rd_data[7];
              ptr    <= ptr + 8'h01;
            end else begin
              state  <= RIMB_PTR;
              sda_oe <= 1'b0;
            end
          end
          RIMB_PTR, RIMB_WDATA: begin
            if (bit_cnt == BITS_PER_BYTE) begin
              state  <= RIMB_ACK_WR;
              sda_oe <= 1'b1;
              if (state == RIMB_PTR) begin
                ptr <= shreg;
              end else begin
                wr_en   <= 1'b1;
                wr_addr <= ptr;
                wr_data <= shreg;
                ptr     <= ptr + 8'h01;
              end
            end
          end
          RIMB_ACK_WR: begin
            state   <= RIMB_WDATA;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
          end
          RIMB_RDATA: begin
            if (bit_cnt == BITS_PER_BYTE) begin
              state  <= RIMB_ACK_RD;
              sda_oe <= 1'b0;
            end else begin
              sda_oe <= ~shreg[7];
            end
          end
          RIMB_ACK_RD: begin
            bit_cnt <= 4'h0;
            if (!nack) begin
              state  <= RIMB_RDATA;
              shreg  <= rd_data;
              sda_oe <= ~rd_data[7];
              ptr    <= ptr + 8'h01;
            end else begin
              state <= RIMB_IDLE;
            end
          end
          default: ;
        endcase
      end
    end
  end

endmodule : rimb_serial_slave
`default_nettype wire

// *** tb_top.sv ***
// Testbench for the mask bank: host model on the serial bus, raw status
// stimulus, flag clears; bus bytes and flag changes checked from queues of expected notes, irq pin and raw status every cycle.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import rimb_pkg::*;
;
  logic       mclk = 1'b0;
  logic       resetn = 1'b0;
  logic       otp = 1'b1;
  logic       rr_evt = 1'b0;
  logic       rr_clr = 1'b0;
  logic [7:0] raw_in = 8'h00;
  logic [3:0] pg_clr = 4'h0;
  logic [3:0] cl_clr = 4'h0;
  logic       scl, sda_low, sda_out, sda_oe, res_stb, rr_f, irq_n, sda_wire;
  logic [7:0] res_byte, raw_st, raw_q;
  logic [3:0] pg_f, cl_f;
  logic [8:0] exp_f = 9'h000;
  logic [8:0] prev_f;
  logic [7:0] bus_q[$];
  logic [8:0] flag_q[$];
  int         n_fail = 0;
  int         checks = 0;
  int         live;
  integer     seed = 32'h08519214;

  always #12.5 mclk = ~mclk;
  // Open-drain data wire with pull-up
  assign sda_wire = !(sda_low || (sda_oe && !sda_out));

  rimb_mask_bank dut (.mclk(mclk), .resetn(resetn), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .otp_reset_mask(otp), .conv0_curlim_raw(raw_in[0]),
    .conv0_pg_raw(raw_in[1]), .conv1_curlim_raw(raw_in[2]),
    .conv1_pg_raw(raw_in[3]), .lin0_curlim_raw(raw_in[4]),
    .lin0_pg_raw(raw_in[5]), .lin1_curlim_raw(raw_in[6]),
    .lin1_pg_raw(raw_in[7]), .reg_reset_event(rr_evt),
    .pg_flag_clr(pg_clr), .curlim_flag_clr(cl_clr),
    .reg_reset_flag_clr(rr_clr), .pg_irq_flag(pg_f),
    .curlim_irq_flag(cl_f), .reg_reset_irq_flag(rr_f),
    .raw_status(raw_st), .irq_out_n(irq_n));

  rimb_host_model host (.mclk(mclk), .sda_in(sda_wire), .scl(scl),
    .sda_low(sda_low), .res_stb(res_stb), .res_byte(res_byte));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  task automatic miss(input string msg);
    n_fail++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : miss

  task automatic cmp_bus(input logic [7:0] got);
    logic [7:0] e;
    checks++;
    if (bus_q.size() == 0) miss("bus byte with no note");
    else begin
      e = bus_q.pop_front();
      if (got !== e) miss($sformatf("bus byte %h, want %h", got, e));
    end
  endtask : cmp_bus

  task automatic cmp_flags(input logic [8:0] got);
    logic [8:0] e;
    checks++;
    if (flag_q.size() == 0) miss($sformatf("flags moved to %h", got));
    else begin
      e = flag_q.pop_front();
      if (got !== e) miss($sformatf("flags %h, want %h", got, e));
    end
  endtask : cmp_flags

  task automatic cmp_level(input logic [7:0] got, input logic [7:0] want,
                           input string what);
    checks++;
    if (got !== want) miss($sformatf("%s %h, want %h", what, got, want));
  endtask : cmp_level

  task automatic conclude;
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////
  // Watchers: bus bytes at posedge, pins at negedge once settled
  always @(posedge mclk) if (res_stb) cmp_bus(res_byte);

  always @(posedge mclk) raw_q <= raw_in;

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) live <= 0;
    else if (live < 4) live <= live + 1;
  end

  always @(negedge mclk) begin
    if (live == 4) begin
      if ({rr_f, cl_f, pg_f} !== prev_f) cmp_flags({rr_f, cl_f, pg_f});
      cmp_level({7'h00, irq_n}, {7'h00, ~|prev_f}, "irq pin");
      cmp_level(raw_st, raw_q, "raw status");
    end
    prev_f = {rr_f, cl_f, pg_f};
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic do_reset(input logic v);
    resetn = 1'b0;
    otp = v;
    tick(12);
    resetn = 1'b1;
    tick(4);
  endtask : do_reset

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    repeat (3) bus_q.push_back(8'h01);
    host.write_reg(DEV_ADDR_DEFAULT, ptr, d);
  endtask : wr

  task automatic rd(input logic [7:0] ptr, input logic [7:0] e[$]);
    repeat (3) bus_q.push_back(8'h01);
    foreach (e[j]) bus_q.push_back(e[j]);
    host.read_regs(ptr, e.size());
  endtask : rd

  task automatic expect_set(input int idx);
    exp_f[idx] = 1'b1;
    flag_q.push_back(exp_f);
  endtask : expect_set

  task automatic pulse_clr(input int idx);
    exp_f[idx] = 1'b0;
    flag_q.push_back(exp_f);
    {rr_clr, cl_clr, pg_clr} = 9'h001 << idx;
    tick(1);
    {rr_clr, cl_clr, pg_clr} = 9'h000;
    tick(3);
  endtask : pulse_clr

  initial begin
    repeat (90000) @(posedge mclk);
    miss("run did not finish");
    conclude();
  end

  initial begin
    int u, k, m, p, f, b;
    logic [7:0] r, keep;
    do_reset(1'b1);
    rd(8'h21, '{8'h01, 8'hcc, 8'hcc});
    rd(8'h30, '{8'h00});
    $display("test defaults done");
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      keep = (i == 0) ? {r[7:1], 1'b1} : r & 8'hdd;
      wr(8'h21 + i[7:0], r);
      rd(8'h21 + i[7:0], '{keep});
    end
    repeat (3) bus_q.push_back(8'h00);
    host.write_reg(DEV_ADDR_DEFAULT ^ 7'h01, 8'h23, 8'h00);
    rd(8'h23, '{keep});
    rr_evt = 1'b1;
    tick(1);
    rr_evt = 1'b0;
    tick(4);
    $display("test register access done");
    for (u = 0; u < 4; u++) for (k = 0; k < 3; k++) for (m = 0; m < 2; m++) begin
      p = (u % 2) * 4 + (k == 0 ? 3 : (k == 1 ? 2 : 0));
      f = (k == 2) ? u + 4 : u;
      b = (k == 2) ? 2 * u : 2 * u + 1;
      wr(u < 2 ? 8'h22 : 8'h23, m ? 8'hdd : 8'hdd & ~(8'h01 << p));
      if (m == 0 && k != 1) expect_set(f);
      raw_in[b] = 1'b1;
      tick(3 + ($random(seed) & 3));
      if (m == 0 && k == 1) expect_set(f);
      raw_in[b] = 1'b0;
      tick(4);
      if (m == 0) pulse_clr(f);
    end
    $display("test event masking done");
    do_reset(1'b0);
    rd(8'h21, '{8'h00});
    wr(8'h21, 8'h01);
    rd(8'h21, '{8'h00});
    expect_set(8);
    rr_evt = 1'b1;
    tick(1);
    rr_evt = 1'b0;
    tick(4);
    pulse_clr(8);
    $display("test reset event done");
    if (bus_q.size() != 0 || flag_q.size() != 0) miss("notes left unmet");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
